// ---- sac_params.svh ----
// constants for the adc conversion control block
`ifndef SAC_PARAMS_SVH
`define SAC_PARAMS_SVH
// register offsets (word index on the plain port)
`define SAC_OFS_CTRL_A      4'h0
`define SAC_OFS_CTRL_C      4'h1
`define SAC_OFS_CTRL_D      4'h2
`define SAC_OFS_SAMP_CTRL   4'h3
`define SAC_OFS_MUX         4'h4
`define SAC_OFS_CMD         4'h5
`define SAC_OFS_EVENT_CONTROL_REG      4'h6
`define SAC_OFS_INT_EN      4'h7
`define SAC_OFS_INT_FLAG    4'h8
`define SAC_OFS_RESULT      4'h9
`define SAC_OFS_DBG         4'hA
`define SAC_OFS_RESULT_HI   4'hB
// control a fields
`define SAC_BIT_ENABLE      0
`define SAC_BIT_FREE_RUNNING_BIT     1
`define SAC_BIT_RESOLUTION_SELECT      2
// control c fields
`define SAC_PRESCALER_FIELD_LSB       0
`define SAC_PRESCALER_FIELD_MSB       2
`define SAC_REF_LSB         4
`define SAC_REF_MSB         5
// reset values
`define SAC_REF_RESET       2'h0
`define SAC_PRESCALER_FIELD_RESET     3'h0
// timing in adc clock cycles
`define SAC_CONV_CYCLES     5'h0D
`define SAC_SH_CYCLES       5'h02
`define SAC_SAMP_BASE       5'h02
// peripheral clock
`define SAC_MCLK_MHZ        20
`endif

// ---- sac_pkg.sv ----
// types for the adc conversion control block
package sac_pkg;
  typedef enum logic [1:0]
  {
    SAC_IDLE  = 2'b00,  // no conversion, prescaler held
    SAC_ALIGN = 2'b01,  // waiting for first adc clock edge
    SAC_CONV  = 2'b10   // conversion running
  } sac_state_type;
endpackage

// ---- sac_adc_ctrl.sv ----
// conversion control for a successive-approximation adc
//=============================================================
// What this block does
// - debug halt stops converter unless debug-run set
// - start bit begins conversion, reads one throughout
// - channel change waits for running conversion end
// - completion sets result-ready, irq when both enabled
// - result-ready set even with interrupt disabled
// - event edge starts conversion, sets start bit
// - free-running restarts immediately while start bit set
// - prescaler runs while enabled, not idle and not debug-halted, zero when disabled or idle
// - start aligns to next adc clock rising edge
// - conversion thirteen adc cycles, sample at two
// - result-ready clears on result read or write-one
// - sampling stretched by delay and length fields
// - shadow selections copied while idle
// - selections frozen, reopen in final cycle
// - free-run next result uses old channel
// - reference resets to internal reference
// - ten-bit right-adjusted result
// - selections ineffective until enable set
`timescale 1ns/10ps
`include "sac_params.svh"
module sac_adc_ctrl
(
  input  wire logic        mclk,             // peripheral clock
  input  wire logic        rst,              // synchronous reset
  input  wire logic [3:0]  addr,             // register index
  input  wire logic [7:0]  wdata,            // write data
  input  wire logic        wr,               // write strobe
  input  wire logic        rd,               // read strobe
  output logic      [7:0]  rdata,            // read data, cycle after rd
  input  wire logic        start_event,      // event routing system input
  input  wire logic        debug_halt,       // cpu halted by debugger
  input  wire logic        global_int_en,    // global interrupt enable
  input  wire logic [9:0]  sar_data,         // result from sar core
  output logic             sar_clk,          // adc clock to the core
  output logic             sar_sample,       // sample-and-hold instant
  output logic             sar_done,         // conversion end pulse
  output logic [4:0]       active_channel,   // channel in force
  output logic [1:0]       active_reference, // reference in force
  output logic             result_irq        // result-ready request
);
  //=============================================================
  // software registers
  logic [2:0]  control_a_reg;      // enable, free-run, resolution
  logic [2:0]  prescaler_field;    // divide select
  logic [1:0]  reference_select;   // shadow reference
  logic [3:0]  sample_delay_field; // extra sample cycles
  logic [3:0]  sample_length_field;// extra sample cycles
  logic [4:0]  positive_input_channel_select; // shadow channel
  logic        start_conversion_bit;
  logic        start_event_input_enable;
  logic        interrupt_enable_reg;
  logic        result_ready_flag;
  logic        debug_run_bit;
  logic [9:0]  result;             // right-adjusted result
  logic        event_prev;         // edge detect history
  logic [7:0]  prescaler_field_cnt;          // prescaler counter
  logic [5:0]  adc_cnt;            // adc cycles into conversion, room for 13+15+15
  sac_pkg::sac_state_type state;
  sac_pkg::sac_state_type next_state;

  //=============================================================
  // decode
  wire enable   = control_a_reg[`SAC_BIT_ENABLE];
  wire free_running_bit  = control_a_reg[`SAC_BIT_FREE_RUNNING_BIT];
  wire wr_a     = wr && addr == `SAC_OFS_CTRL_A;
  wire wr_c     = wr && addr == `SAC_OFS_CTRL_C;
  wire wr_cmd   = wr && addr == `SAC_OFS_CMD && wdata[0];
  wire wr_flag  = wr && addr == `SAC_OFS_INT_FLAG && wdata[0];
  wire rd_res   = rd && addr == `SAC_OFS_RESULT;
  // halted unless debug-run set
  wire run_ok   = !debug_halt || debug_run_bit;
  // edge sensitive event start
  wire ev_start = start_event_input_enable && start_event && !event_prev;
  wire start_req = enable && (wr_cmd || ev_start);
  // power-of-two divider; bit (prescaler_field) toggles at factor/2
  wire [7:0] prescaler_field_mask = 8'h01 << prescaler_field;
  // adc clock rising edge: counter wraps at the factor
  wire adc_rise = ((prescaler_field_cnt & ((prescaler_field_mask << 1) - 8'h01)) == ((prescaler_field_mask << 1) - 8'h01))
                  && run_ok;
  // total conversion length, sample stretch included
  // six bits: both fields at full scale would wrap a five-bit sum
  wire [5:0] conv_len = {1'b0, `SAC_CONV_CYCLES} + {2'b00, sample_delay_field}
                        + {2'b00, sample_length_field};
  wire [5:0] samp_pos = {1'b0, `SAC_SAMP_BASE} + {2'b00, sample_delay_field}
                        + {2'b00, sample_length_field};
  wire sample_end = adc_cnt == samp_pos;
  wire last_cyc = state == sac_pkg::SAC_CONV && adc_cnt == conv_len - 6'h01;
  wire finish   = last_cyc && adc_rise;
  // selections track shadows while idle or in the last cycle
  wire sel_open = enable && (state != sac_pkg::SAC_CONV || last_cyc);

  //=============================================================
  // conversion sequencing
  always_comb
  begin
    next_state = state;
    unique case (state)
      sac_pkg::SAC_IDLE:
        if (start_req) next_state = sac_pkg::SAC_ALIGN;
      sac_pkg::SAC_ALIGN:
        if (!enable) next_state = sac_pkg::SAC_IDLE;
        else if (adc_rise) next_state = sac_pkg::SAC_CONV;
      sac_pkg::SAC_CONV:
        if (!enable) next_state = sac_pkg::SAC_IDLE;
        // free-run goes straight into the next conversion
        else if (finish) next_state = free_running_bit ? sac_pkg::SAC_CONV
                                              : sac_pkg::SAC_IDLE;
      default:
        next_state = sac_pkg::SAC_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge mclk)
  begin
    if (rst) state <= sac_pkg::SAC_IDLE;
    else     state <= next_state;
  end

  // prescaler: held while disabled or idle, gives fixed start delay
  always_ff @(posedge mclk)
  begin
    if (rst || !enable || state == sac_pkg::SAC_IDLE) prescaler_field_cnt <= 8'h00;
    else if (run_ok) prescaler_field_cnt <= prescaler_field_cnt + 8'h01;
  end

  // adc cycle counter within conversion
  always_ff @(posedge mclk)
  begin
    if (rst || state != sac_pkg::SAC_CONV || finish) adc_cnt <= 6'h00;
    else if (adc_rise) adc_cnt <= adc_cnt + 6'h01;
  end

  // adc clock and core strobes from flops
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      sar_clk    <= 1'b0;
      sar_sample <= 1'b0;
      sar_done   <= 1'b0;
    end
    else
    begin
      sar_clk    <= (prescaler_field_cnt & prescaler_field_mask) != 8'h00;
      // hold instant after the stretched sampling window
      sar_sample <= state == sac_pkg::SAC_CONV && adc_rise && sample_end;
      sar_done   <= finish;
    end
  end

  // active selections; frozen during conversion, so a mid-run change
  // lands on the following conversion
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      active_channel   <= 5'h00;
      active_reference <= `SAC_REF_RESET;
    end
    else if (sel_open)
    begin
      active_channel   <= positive_input_channel_select;
      active_reference <= reference_select;
    end
  end

  // start bit: set by command or event, cleared at end of single run
  always_ff @(posedge mclk)
  begin
    if (rst || !enable) start_conversion_bit <= 1'b0;
    else if (start_req) start_conversion_bit <= 1'b1;
    else if (finish && !free_running_bit) start_conversion_bit <= 1'b0;
  end

  // result and ready flag; set wins over clear
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      result            <= 10'h000;
      result_ready_flag <= 1'b0;
    end
    else if (finish)
    begin
      result            <= sar_data;
      result_ready_flag <= 1'b1;
    end
    else if (rd_res || wr_flag) result_ready_flag <= 1'b0;
  end

  // interrupt request only with both enables
  assign result_irq = result_ready_flag && interrupt_enable_reg && global_int_en;

  // event history
  always_ff @(posedge mclk)
  begin
    if (rst) event_prev <= 1'b0;
    else     event_prev <= start_event;
  end

  //=============================================================
  // register writes
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      control_a_reg       <= 3'h0;
      prescaler_field     <= `SAC_PRESCALER_FIELD_RESET;
      reference_select    <= `SAC_REF_RESET;
      sample_delay_field  <= 4'h0;
      sample_length_field <= 4'h0;
      positive_input_channel_select <= 5'h00;
      start_event_input_enable <= 1'b0;
      interrupt_enable_reg <= 1'b0;
      debug_run_bit       <= 1'b0;
    end
    else if (wr)
    begin
      if (wr_a) control_a_reg <= wdata[2:0];
      if (wr_c)
      begin
        prescaler_field  <= wdata[`SAC_PRESCALER_FIELD_MSB:`SAC_PRESCALER_FIELD_LSB];
        reference_select <= wdata[`SAC_REF_MSB:`SAC_REF_LSB];
      end
      if (addr == `SAC_OFS_CTRL_D)    sample_delay_field <= wdata[3:0];
      if (addr == `SAC_OFS_SAMP_CTRL) sample_length_field <= wdata[3:0];
      if (addr == `SAC_OFS_MUX)       positive_input_channel_select <= wdata[4:0];
      if (addr == `SAC_OFS_EVENT_CONTROL_REG)    start_event_input_enable <= wdata[0];
      if (addr == `SAC_OFS_INT_EN)    interrupt_enable_reg <= wdata[0];
      if (addr == `SAC_OFS_DBG)       debug_run_bit <= wdata[0];
    end
  end

  //=============================================================
  // read mux; unmapped reads give zero
  logic [7:0] rd_mux;
  always_comb
  begin
    rd_mux = 8'h00;
    unique case (addr)
      `SAC_OFS_CTRL_A:    rd_mux = {5'h00, control_a_reg};
      `SAC_OFS_CTRL_C:    rd_mux = {2'h0, reference_select, 1'b0, prescaler_field};
      `SAC_OFS_CTRL_D:    rd_mux = {4'h0, sample_delay_field};
      `SAC_OFS_SAMP_CTRL: rd_mux = {4'h0, sample_length_field};
      `SAC_OFS_MUX:       rd_mux = {3'h0, positive_input_channel_select};
      `SAC_OFS_CMD:       rd_mux = {7'h00, start_conversion_bit};
      `SAC_OFS_EVENT_CONTROL_REG:    rd_mux = {7'h00, start_event_input_enable};
      `SAC_OFS_INT_EN:    rd_mux = {7'h00, interrupt_enable_reg};
      `SAC_OFS_INT_FLAG:  rd_mux = {7'h00, result_ready_flag};
      `SAC_OFS_RESULT:    rd_mux = result[7:0];
      `SAC_OFS_DBG:       rd_mux = {7'h00, debug_run_bit};
      `SAC_OFS_RESULT_HI: rd_mux = {6'h00, result[9:8]};
      default:            rd_mux = 8'h00;
    endcase
  end

  // read data registered, stands one cycle
  always_ff @(posedge mclk)
  begin
    if (rst)     rdata <= 8'h00;
    else if (rd) rdata <= rd_mux;
    else         rdata <= 8'h00;
  end
endmodule

// ---- sac_sar_model.sv ----
// behavioural sar core: result encodes selection seen at sample instant
`timescale 1ns/10ps
module sac_sar_model
(
  input  wire logic       mclk,             // peripheral clock
  input  wire logic       rst,              // sync reset
  input  wire logic       sar_sample,       // sample-and-hold instant
  input  wire logic [4:0] active_channel,   // channel in force
  input  wire logic [1:0] active_reference, // reference in force
  output logic      [9:0] sar_data          // converted value
);
  //==========================================
  // sample capture
  // latched at sample so late mux changes cannot leak into the value
  always_ff @(posedge mclk)
  begin
    if (rst)
      sar_data <= 10'h3FF;
    else if (sar_sample)
      sar_data <= {3'h0, active_reference, active_channel};
  end
endmodule

// ---- sac_adc_ctrl_properties.sv ----
// port checker for the adc conversion control block
`timescale 1ns/10ps
module sac_adc_ctrl_properties
(
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic       rd,
  input wire logic       wr,
  input wire logic       global_int_en,
  input wire logic [7:0] rdata,
  input wire logic       sar_sample,
  input wire logic       sar_done,
  input wire logic [4:0] active_channel,
  input wire logic [1:0] active_reference,
  input wire logic       result_irq
);
  //==========================================
  // properties
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_sampled; $rose(sar_sample); endsequence
  sequence s_finish; ##[1:1000] sar_done; endsequence
  irq_gate_a: assert property (result_irq |-> global_int_en) else $error("irq without gie");
  reset_clear_a: assert property ($past(rst) |-> active_reference == 2'h0 && !result_irq)
    else $error("reset state wrong");
  rdata_idle_a: assert property (!rd |=> rdata == 8'h00) else $error("rdata not idle");
  sample_done_a: assert property (s_sampled |-> s_finish) else $error("no finish");
  sample_excl_a: assert property (sar_sample |-> !sar_done) else $error("sample at done");
  done_pulse_a: assert property (sar_done |=> !sar_done) else $error("done too long");
  chan_lock_a: assert property (sar_sample |-> $stable(active_channel))
    else $error("channel moved");
  irq_fall_a: assert property ($fell(result_irq) && $stable(global_int_en) && $past(!rst)
    |-> $past(wr || rd)) else $error("flag dropped alone");
endmodule
bind sac_adc_ctrl sac_adc_ctrl_properties u_sac_adc_ctrl_properties
(
  .mclk(mclk), .rst(rst), .rd(rd), .wr(wr), .global_int_en(global_int_en),
  .rdata(rdata), .sar_sample(sar_sample), .sar_done(sar_done),
  .active_channel(active_channel), .active_reference(active_reference),
  .result_irq(result_irq)
);

// ---- tb_top.sv ----
// testbench for the adc conversion control block
`timescale 1ns/10ps
module tb_top;
  logic       mclk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
  logic       start_event = 1'b0, debug_halt = 1'b0, global_int_en = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic [9:0] v;
  wire  [7:0] rdata;
  wire  [9:0] sar_data;
  wire  [4:0] active_channel;
  wire  [1:0] active_reference;
  wire        sar_clk, sar_sample, sar_done, result_irq;
  int         err_total = 0, samples_checked = 0, n;
  always #25 mclk = ~mclk;
  sac_adc_ctrl u_sac_adc_ctrl (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .start_event(start_event), .debug_halt(debug_halt),
    .global_int_en(global_int_en), .sar_data(sar_data), .sar_clk(sar_clk),
    .sar_sample(sar_sample), .sar_done(sar_done), .active_channel(active_channel),
    .active_reference(active_reference), .result_irq(result_irq));
  sac_sar_model u_sac_sar_model (.mclk(mclk), .rst(rst), .sar_sample(sar_sample),
    .active_channel(active_channel), .active_reference(active_reference), .sar_data(sar_data));
  //==========================================
  // shared tasks
  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rd_reg(input logic [3:0] a);
    @(posedge mclk);
    addr <= a; rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 v = {2'h0, rdata};
  endtask
  // bounded wait; n reaches 300 when no finish came
  task automatic wait_done();
    n = 0;
    do
    begin
      @(posedge mclk);
      #1 n++;
    end while (sar_done !== 1'b1 && n < 300);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  //==========================================
  // scenarios
  task automatic t_single();
    rd_reg(4'h1); check(v & 10'h030, 10'h000);
    wr_reg(4'h4, 8'h05);
    wr_reg(4'h1, 8'h03);
    wr_reg(4'h0, 8'h01);
    wr_reg(4'h5, 8'h01);
    rd_reg(4'h5); check(v, 10'h001);
    // past alignment and half an adc clock into the conversion, before its first adc clock, before moving the channel
    repeat (20) @(posedge mclk);
    wr_reg(4'h4, 8'h0A);
    wait_done();
    rd_reg(4'h8); check(v, 10'h001);
    check(result_irq, 10'h000);
    rd_reg(4'h5); check(v, 10'h000);
    rd_reg(4'h9); check(v, 10'h005);
    rd_reg(4'hB); check(v, 10'h000);
    rd_reg(4'h8); check(v, 10'h000);
    $display("single test ended");
  endtask
  task automatic t_event();
    wr_reg(4'h7, 8'h01); @(posedge mclk) global_int_en <= 1'b1; wr_reg(4'h6, 8'h01);
    @(posedge mclk) start_event <= 1'b1;
    rd_reg(4'h5); check(v, 10'h001);
    start_event <= 1'b0;
    wait_done(); #60;
    check(result_irq, 10'h001);
    wr_reg(4'h8, 8'h01); check(result_irq, 10'h000);
    rd_reg(4'h9); check(v, 10'h00A);
    $display("event test ended");
  endtask
  task automatic t_free();
    wr_reg(4'h2, 8'h01); wr_reg(4'h3, 8'h02); wr_reg(4'h0, 8'h03); wr_reg(4'h5, 8'h01);
    wait_done(); wait_done();
    check(10'(n), 10'h100);
    rd_reg(4'h5); check(v, 10'h001);
    wr_reg(4'h0, 8'h00); wr_reg(4'h2, 8'h00); wr_reg(4'h3, 8'h00); wr_reg(4'h0, 8'h01);
    $display("free-run test ended");
  endtask
  task automatic t_debug();
    @(posedge mclk) debug_halt <= 1'b1; wr_reg(4'h5, 8'h01);
    wait_done(); check(10'(n), 10'h12C);
    wr_reg(4'hA, 8'h01);
    wait_done(); check(n < 300, 10'h001);
    debug_halt <= 1'b0;
    $display("debug test ended");
  endtask
  initial
  begin
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    t_single(); t_event(); t_free(); t_debug();
    test_done();
  end
  initial
  begin
    #250000;
    err_total++;
    test_done();
  end
endmodule
